// ### sep_pkg.sv
// Shared constants, types and state codes for the serial memory slave front end
// How it works
// - Reset and supply loss return to standby
// - Sample on SCL rise, drive on fall
// - Write guard high blocks all writes
// - SDA change with SCL high is control
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Ignore the bus until a START
// - Respond only to prefix 1010
// - Chip select bit must match pin
// - Last address bit: one read, zero write
// - Acknowledge address, byte address, write data
// - Read: release ninth clock, continue on ack
// - Byte write commits at the following STOP
// - Busy: SDA released, no response at all
// - At most sixteen bytes per write cycle
// - Writes increment only the low four address bits
// - Page counter wraps, later bytes overwrite
// - STOP writes all buffered bytes together
// - Nack own address while busy, ack after
// - Zero pulls SDA low, one releases it
// - Guard sampled before first data byte
// - Read address returns current location byte
// - Random read via dummy write, repeated START
// - Sequential read wraps at end of memory
package sep_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int WR_TIME_US = 4000;
    localparam int WR_CYCLES = WR_TIME_US * (CLK_HZ / 1_000_000);

    localparam logic [3:0] DEV_PREFIX = 4'hA;
    localparam int CS_BIT = 3;
    localparam int UPA_HI = 2;
    localparam int UPA_LO = 1;
    localparam int RW_BIT = 0;
    localparam int ADDR_W = 10;
    localparam int PAGE_BYTES = 16;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] LAST_IDX = 4'hF;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_DEVADR = 3'h1,
        ST_WORDADR = 3'h2,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h4,
        ST_IGNORE = 3'h5
    } sep_state_t;

    typedef enum logic [1:0]
    {
        CM_IDLE = 2'h0,
        CM_PUSH = 2'h1,
        CM_WAIT = 2'h2
    } sep_commit_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } sep_word_t;

endpackage : sep_pkg

// ### sep_buf.sv
// Small valid/ready buffer between page commit and the storage array
module sep_buf #(
    parameter int W = 18,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,         // System clock
    input wire logic rst_b_i,       // Async reset, active low
    input wire logic in_valid_i,    // Word offered
    output logic in_ready_o,        // Room for a word
    input wire logic [W-1:0] in_data_i, // Word in
    output logic out_valid_o,       // Word available
    input wire logic out_ready_i,   // Sink takes word
    output logic [W-1:0] out_data_o // Word out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] next_mem [DEPTH];
    logic [PW-1:0] wp, rp, next_wp, next_rp;
    logic [PW:0] cnt, next_cnt;
    logic push, pop;

    assign in_ready_o = (cnt != (PW + 1)'(DEPTH));
    assign out_valid_o = (cnt != '0);
    assign out_data_o = mem[rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb
    begin
        next_mem = mem;
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (push)
        begin
            next_mem[wp] = in_data_i;
            next_wp = (wp == PLAST) ? '0 : wp + 1'b1;
        end
        if (pop)
        begin
            next_rp = (rp == PLAST) ? '0 : rp + 1'b1;
        end
        if (push && !pop)
        begin
            next_cnt = cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            mem <= next_mem;
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

endmodule : sep_buf

// ### sep_slave.sv
// Two-wire slave front end: framing, addressing, page buffer, commit and busy
module sep_slave #(
    parameter int WRITE_CYCLES = sep_pkg::WR_CYCLES
) (
    input wire logic CLK_I,                 // System clock, 25 MHz
    input wire logic RST_B_I,               // Async reset, active low
    input wire logic SCL_I,                 // Serial clock pin
    input wire logic SDA_I,                 // Serial data pin level
    output logic SDA_O,                     // Serial data out, always low
    output logic SDA_OE_O,                  // High while pulling SDA low
    input wire logic CHIP_SELECT_PIN_I,     // Strap for the select bit
    input wire logic WRITE_GUARD_I,         // High blocks writes
    output logic [sep_pkg::ADDR_W-1:0] RD_ADDR_O, // Storage read address
    input wire logic [7:0] RD_DATA_I,       // Storage read data
    output logic WR_VALID_O,                // Storage write word valid
    input wire logic WR_READY_I,            // Storage accepts word
    output sep_pkg::sep_word_t WR_WORD_O,   // Storage write word
    output logic BUSY_O                     // Internal write cycle running
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus conditions

    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic wp_s1, wp_s2, cs_s1, cs_s2;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            wp_s1 <= 1'b0;
            wp_s2 <= 1'b0;
            cs_s1 <= 1'b0;
            cs_s2 <= 1'b0;
        end
        else
        begin
            scl_s1 <= SCL_I;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= SDA_I;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            wp_s1 <= WRITE_GUARD_I;
            wp_s2 <= wp_s1;
            cs_s1 <= CHIP_SELECT_PIN_I;
            cs_s2 <= cs_s1;
        end
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    // Any SDA edge while SCL stays high is a control condition
    assign start_cond = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_cond = scl_s2 && scl_d && !sda_d && sda_s2;

    ////////////////////////////////////////////////////////////////////////
    // Protocol state

    sep_pkg::sep_state_t state, next_state;
    sep_pkg::sep_commit_t cm, next_cm;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic ack_slot, next_ack_slot;
    logic [7:0] shreg, next_shreg;
    logic [7:0] tx, next_tx;
    logic sda_oe, next_sda_oe;
    logic rw, next_rw;
    logic mack, next_mack;
    logic wp_block, next_wp_block;
    logic [sep_pkg::ADDR_W-1:0] addr, next_addr;
    logic [7:0] page [sep_pkg::PAGE_BYTES];
    logic [7:0] next_page [sep_pkg::PAGE_BYTES];
    logic [sep_pkg::PAGE_BYTES-1:0] page_vld, next_page_vld;
    logic commit_go, busy, dev_match;

    assign busy = (cm != sep_pkg::CM_IDLE);
    assign dev_match = (shreg[7:4] == sep_pkg::DEV_PREFIX)
        && (shreg[sep_pkg::CS_BIT] == cs_s2)
        && !busy;

    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_ack_slot = ack_slot;
        next_shreg = shreg;
        next_tx = tx;
        next_sda_oe = sda_oe;
        next_rw = rw;
        next_mack = mack;
        next_wp_block = wp_block;
        next_addr = addr;
        next_page = page;
        next_page_vld = page_vld;
        commit_go = 1'b0;
        if (start_cond)
        begin
            // Every command begins here; repeated START included
            next_state = sep_pkg::ST_DEVADR;
            next_bit_cnt = '0;
            next_ack_slot = 1'b0;
            next_sda_oe = 1'b0;
            next_wp_block = 1'b0;
            if (!busy)
            begin
                next_page_vld = '0;
            end
        end
        else if (stop_cond)
        begin
            // Only a clean, unguarded write with data commits
            if (state == sep_pkg::ST_WDATA && |page_vld && !wp_block)
            begin
                commit_go = 1'b1;
            end
            next_state = sep_pkg::ST_IDLE;
            next_ack_slot = 1'b0;
            next_sda_oe = 1'b0;
        end
        else if (state != sep_pkg::ST_IDLE && state != sep_pkg::ST_IGNORE)
        begin
            if (scl_rise)
            begin
                if (ack_slot)
                begin
                    next_mack = !sda_s2;
                end
                else if (bit_cnt != sep_pkg::ACK_BIT)
                begin
                    next_shreg = {shreg[6:0], sda_s2};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
            end
            else if (scl_fall)
            begin
                if (ack_slot)
                begin
                    // End of the ninth clock
                    next_ack_slot = 1'b0;
                    next_bit_cnt = '0;
                    next_sda_oe = 1'b0;
                    unique case (state)
                        sep_pkg::ST_DEVADR:
                        begin
                            if (rw)
                            begin
                                next_state = sep_pkg::ST_RDATA;
                                next_tx = RD_DATA_I;
                                next_sda_oe = !RD_DATA_I[7];
                            end
                            else
                            begin
                                next_state = sep_pkg::ST_WORDADR;
                            end
                        end
                        sep_pkg::ST_WORDADR:
                        begin
                            next_state = sep_pkg::ST_WDATA;
                            next_wp_block = wp_s2;
                        end
                        sep_pkg::ST_WDATA:
                        begin
                            next_state = sep_pkg::ST_WDATA;
                        end
                        sep_pkg::ST_RDATA:
                        begin
                            if (mack)
                            begin
                                next_tx = RD_DATA_I;
                                next_sda_oe = !RD_DATA_I[7];
                            end
                            else
                            begin
                                next_state = sep_pkg::ST_IGNORE;
                            end
                        end
                        default:
                        begin
                            next_state = sep_pkg::ST_IGNORE;
                        end
                    endcase
                end
                else if (bit_cnt == sep_pkg::ACK_BIT)
                begin
                    // Byte complete: decide the ninth clock
                    next_ack_slot = 1'b1;
                    unique case (state)
                        sep_pkg::ST_DEVADR:
                        begin
                            if (dev_match)
                            begin
                                next_sda_oe = 1'b1;
                                next_rw = shreg[sep_pkg::RW_BIT];
                                next_addr[9:8] = shreg[sep_pkg::UPA_HI:sep_pkg::UPA_LO];
                            end
                            else
                            begin
                                // Silent when busy or not addressed
                                next_ack_slot = 1'b0;
                                next_state = sep_pkg::ST_IGNORE;
                            end
                        end
                        sep_pkg::ST_WORDADR:
                        begin
                            next_sda_oe = 1'b1;
                            next_addr[7:0] = shreg;
                        end
                        sep_pkg::ST_WDATA:
                        begin
                            if (wp_block)
                            begin
                                // Guarded: nack and drop the write
                                next_ack_slot = 1'b0;
                                next_state = sep_pkg::ST_IGNORE;
                            end
                            else
                            begin
                                next_sda_oe = 1'b1;
                                // Wrap in page, later bytes overwrite
                                next_page[addr[3:0]] = shreg;
                                next_page_vld[addr[3:0]] = 1'b1;
                                next_addr[3:0] = addr[3:0] + 4'h1;
                            end
                        end
                        sep_pkg::ST_RDATA:
                        begin
                            next_sda_oe = 1'b0;
                            next_addr = addr + 10'h001;
                        end
                        default:
                        begin
                            next_state = sep_pkg::ST_IGNORE;
                        end
                    endcase
                end
                else if (state == sep_pkg::ST_RDATA && bit_cnt != 4'h0)
                begin
                    next_sda_oe = !tx[3'(4'h7 - bit_cnt)];
                end
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state <= sep_pkg::ST_IDLE;
            bit_cnt <= '0;
            ack_slot <= 1'b0;
            shreg <= '0;
            tx <= '0;
            sda_oe <= 1'b0;
            rw <= 1'b0;
            mack <= 1'b0;
            wp_block <= 1'b0;
            addr <= '0;
            page_vld <= '0;
            for (int i = 0; i < sep_pkg::PAGE_BYTES; i++)
            begin
                page[i] <= '0;
            end
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            ack_slot <= next_ack_slot;
            shreg <= next_shreg;
            tx <= next_tx;
            sda_oe <= next_sda_oe;
            rw <= next_rw;
            mack <= next_mack;
            wp_block <= next_wp_block;
            addr <= next_addr;
            page_vld <= next_page_vld;
            page <= next_page;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commit of the page and internal write timer

    logic [3:0] idx, next_idx;
    logic [31:0] timer, next_timer;
    logic push_valid, push_ready, buf_out_valid;
    sep_pkg::sep_word_t push_word;

    assign push_valid = (cm == sep_pkg::CM_PUSH) && page_vld[idx];
    assign push_word.addr = {addr[9:4], idx};
    assign push_word.data = page[idx];

    always_comb
    begin
        next_cm = cm;
        next_idx = idx;
        next_timer = timer;
        unique case (cm)
            sep_pkg::CM_IDLE:
            begin
                if (commit_go)
                begin
                    next_cm = sep_pkg::CM_PUSH;
                    next_idx = '0;
                end
            end
            sep_pkg::CM_PUSH:
            begin
                // A stalled storage side holds the walk here
                if (!page_vld[idx] || push_ready)
                begin
                    next_idx = idx + 4'h1;
                    if (idx == sep_pkg::LAST_IDX)
                    begin
                        next_cm = sep_pkg::CM_WAIT;
                        next_timer = '0;
                    end
                end
            end
            sep_pkg::CM_WAIT:
            begin
                // Write time runs once the buffer has drained
                if (!buf_out_valid)
                begin
                    next_timer = timer + 32'h1;
                    if (timer >= 32'(WRITE_CYCLES - 1))
                    begin
                        next_cm = sep_pkg::CM_IDLE;
                    end
                end
            end
            default:
            begin
                next_cm = sep_pkg::CM_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            cm <= sep_pkg::CM_IDLE;
            idx <= '0;
            timer <= '0;
        end
        else
        begin
            cm <= next_cm;
            idx <= next_idx;
            timer <= next_timer;
        end
    end

    sep_buf #(
        .W($bits(sep_pkg::sep_word_t)),
        .DEPTH(sep_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(buf_out_valid),
        .out_ready_i(WR_READY_I),
        .out_data_o(WR_WORD_O)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs; SCL is never driven

    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe;
    assign RD_ADDR_O = addr;
    assign WR_VALID_O = buf_out_valid;
    assign BUSY_O = busy;

endmodule : sep_slave

// ### sep_slave_properties.sv
// Port-level assertions for the serial memory slave
module sep_slave_chk #(
    parameter int WRITE_CYCLES = sep_pkg::WR_CYCLES
) (
    input wire logic CLK_I,                  // System clock
    input wire logic RST_B_I,                // Async reset, active low
    input wire logic SCL_I,                  // Serial clock pin
    input wire logic SDA_I,                  // Resolved data wire
    input wire logic SDA_O,                  // Data out level
    input wire logic SDA_OE_O,               // Slave pulls data low
    input wire logic [sep_pkg::ADDR_W-1:0] RD_ADDR_O, // Read address
    input wire logic WR_VALID_O,             // Word offered
    input wire logic WR_READY_I,             // Storage takes word
    input wire sep_pkg::sep_word_t WR_WORD_O, // Write word
    input wire logic BUSY_O                  // Write cycle running
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    logic sda_q;
    logic scl_q;
    logic in_frame;
    logic [5:0] page_r;
    int busy_cnt;
    int hs_cnt;
    wire logic hs = WR_VALID_O && WR_READY_I;
    // Framing seen at the pins, ahead of the slave's synchroniser lag
    wire logic start_ev = scl_q && SCL_I && sda_q && !SDA_I;
    wire logic stop_ev = scl_q && SCL_I && !sda_q && SDA_I;
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            in_frame <= 1'b0;
            page_r <= 6'h00;
            busy_cnt <= 0;
            hs_cnt <= 0;
        end
        else
        begin
            sda_q <= SDA_I;
            scl_q <= SCL_I;
            in_frame <= start_ev || (in_frame && !stop_ev);
            busy_cnt <= BUSY_O ? busy_cnt + 1 : 0;
            hs_cnt <= !BUSY_O ? 0 : hs ? hs_cnt + 1 : hs_cnt;
            page_r <= (hs && hs_cnt == 0) ? WR_WORD_O.addr[9:4] : page_r;
        end
    end
    sequence s_stall;
        WR_VALID_O && !WR_READY_I;
    endsequence
    sequence s_push;
        ##[0:16] WR_VALID_O;
    endsequence
    ////////////////////////////////////////////////////////////
    AST_RST_QUIET: assert property ($rose(RST_B_I) |-> !SDA_OE_O && !BUSY_O
        && !WR_VALID_O && RD_ADDR_O == 10'h000) else $error("outputs not idle after reset");
    AST_OE_SCL_LOW: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("data output moved with clock high");
    AST_DRIVE_LOW: assert property (SDA_OE_O |-> SDA_O == 1'b0)
        else $error("data driven high");
    AST_BUSY_QUIET: assert property (BUSY_O |-> !SDA_OE_O)
        else $error("data driven while busy");
    AST_FRAMED: assert property ($rose(SDA_OE_O) |-> in_frame)
        else $error("answer outside a frame");
    AST_AFTER_STOP: assert property ($rose(BUSY_O) |-> !in_frame ##0 s_push)
        else $error("write cycle not started by stop");
    AST_WORD_HELD: assert property (s_stall |=> WR_VALID_O && $stable(WR_WORD_O))
        else $error("stalled word lost");
    AST_WORD_BUSY: assert property (WR_VALID_O |-> BUSY_O)
        else $error("word offered outside write cycle");
    AST_ONE_PAGE: assert property (hs && hs_cnt != 0 |-> WR_WORD_O.addr[9:4] == page_r)
        else $error("commit left its page");
    AST_PAGE_MAX: assert property (hs |-> hs_cnt < sep_pkg::PAGE_BYTES)
        else $error("too many words in one cycle");
    AST_WR_TIME: assert property ($fell(BUSY_O) |-> busy_cnt >= WRITE_CYCLES)
        else $error("write cycle too short");
endmodule : sep_slave_chk

bind sep_slave sep_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_sep_slave_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
    .SDA_OE_O(SDA_OE_O), .RD_ADDR_O(RD_ADDR_O), .WR_VALID_O(WR_VALID_O),
    .WR_READY_I(WR_READY_I), .WR_WORD_O(WR_WORD_O), .BUSY_O(BUSY_O)
);

// ### sep_master.sv
// Two-wire bus master model for the slave under test
module sep_master (
    input wire logic clk_i,    // Bench clock
    input wire logic dev_oe_i, // Slave pulls data low
    output logic scl_o,        // Serial clock
    output logic sda_o         // Resolved data wire
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 4;
    logic pull = 1'b0;
    logic scl = 1'b1;
    assign scl_o = scl;
    // Open drain with pull-up: low while either side pulls
    assign sda_o = !(pull || dev_oe_i);
    task automatic pause(input int n);
        repeat (n) @(negedge clk_i);
    endtask : pause
    // Only from idle or with the clock low, so no transfer is cut
    task automatic start();
        pull = 1'b0;
        pause(Q);
        scl = 1'b1;
        pause(2 * Q);
        pull = 1'b1;
        pause(2 * Q);
        scl = 1'b0;
        pause(Q);
    endtask : start
    task automatic stop();
        pull = 1'b1;
        pause(Q);
        scl = 1'b1;
        pause(2 * Q);
        pull = 1'b0;
        pause(2 * Q);
    endtask : stop
    task automatic idle_low();
        scl = 1'b0;
        pause(Q);
    endtask : idle_low
    task automatic bit_x(input logic b, output logic r);
        pull = !b;
        pause(Q);
        scl = 1'b1;
        pause(2 * Q);
        r = sda_o;
        scl = 1'b0;
        pause(Q);
    endtask : bit_x
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : put_byte
    task automatic get_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(!mack, r);
    endtask : get_byte
endmodule : sep_master

// ### sep_slave_tb.sv
// Self-checking bench: framing, addressing, page writes, polling, reads
module sep_slave_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WC = 400;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_pin = 1'b0;
    logic guard = 1'b0;
    logic wr_ready = 1'b1;
    logic sda_oe, sda_out, scl, sda, wr_valid, busy;
    logic [9:0] rd_addr;
    logic [7:0] rd_data;
    sep_pkg::sep_word_t wr_word;
    logic [7:0] mem [1024];
    logic [7:0] exp_mem [1024];
    logic [31:0] lfsr = 32'hCF77;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    sep_slave #(.WRITE_CYCLES(WC)) u_sep_slave (
        .CLK_I(clk), .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out),
        .SDA_OE_O(sda_oe), .CHIP_SELECT_PIN_I(cs_pin), .WRITE_GUARD_I(guard),
        .RD_ADDR_O(rd_addr), .RD_DATA_I(rd_data), .WR_VALID_O(wr_valid),
        .WR_READY_I(wr_ready), .WR_WORD_O(wr_word), .BUSY_O(busy));
    sep_master u_sep_master (.clk_i(clk), .dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    assign rd_data = mem[rd_addr];
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
        if (wr_valid && wr_ready)
            mem[wr_word.addr] <= wr_word.data;
    // Storage stalls one cycle in five to exercise the buffer
    always @(negedge clk)
    begin
        wr_ready <= (cycles % 5) != 3;
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            fail_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic [7:0] dev_byte(input logic [1:0] up, input logic rw);
        return {4'hA, cs_pin, up, rw};
    endfunction : dev_byte
    function automatic logic [9:0] page_addr(input logic [9:0] b, input int i);
        return {b[9:4], b[3:0] + 4'(i)};
    endfunction : page_addr
    task automatic summarize();
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic check_val(input logic [15:0] got, input logic [15:0] want);
        num_checks++;
        if (got !== want)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check_val
    task automatic check_flag(input logic got, input logic want);
        check_val({15'h0000, got}, {15'h0000, want});
    endtask : check_flag
    task automatic page_write(input logic [9:0] b, input int n, input logic prot);
        logic a;
        logic [7:0] d;
        u_sep_master.start();
        u_sep_master.put_byte(dev_byte(b[9:8], 1'b0), a);
        check_flag(a, 1'b1);
        u_sep_master.put_byte(b[7:0], a);
        check_flag(a, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            d = 8'(rnd());
            u_sep_master.put_byte(d, a);
            check_flag(a, !prot);
            if (!prot)
                exp_mem[page_addr(b, i)] = d;
        end
        u_sep_master.stop();
        repeat (6) @(negedge clk);
        check_flag(busy, !prot);
    endtask : page_write
    task automatic poll(input logic [1:0] up);
        logic a;
        a = 1'b0;
        for (int k = 0; k < 8 && !a; k++)
        begin
            u_sep_master.start();
            u_sep_master.put_byte(dev_byte(up, 1'b0), a);
            if (k == 0)
                check_flag(a, 1'b0);
            u_sep_master.stop();
        end
        check_flag(a, 1'b1);
    endtask : poll
    task automatic read_check(input logic [9:0] b, input int n);
        logic a;
        logic [7:0] d;
        u_sep_master.start();
        u_sep_master.put_byte(dev_byte(b[9:8], 1'b0), a);
        u_sep_master.put_byte(b[7:0], a);
        u_sep_master.start();
        u_sep_master.put_byte(dev_byte(b[9:8], 1'b1), a);
        check_flag(a, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            u_sep_master.get_byte(i != n - 1, d);
            check_val(16'(d), 16'(exp_mem[10'(b + i)]));
        end
        u_sep_master.stop();
    endtask : read_check
    ////////////////////////////////////////////////////////////
    initial
    begin
        logic a;
        logic [7:0] d;
        logic [9:0] pg;
        for (int i = 0; i < 1024; i++)
        begin
            mem[i] = 8'(rnd());
            exp_mem[i] = mem[i];
        end
        cs_pin = 1'(rnd());
        repeat (4) @(negedge clk);
        check_flag(sda_oe | busy | wr_valid, 1'b0);
        check_val(16'(rd_addr), 16'h0000);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        u_sep_master.idle_low();
        u_sep_master.put_byte(dev_byte(2'b00, 1'b0), a);
        check_flag(a, 1'b0);
        u_sep_master.stop();
        for (int j = 0; j < 2; j++)
        begin
            u_sep_master.start();
            u_sep_master.put_byte(j == 0 ? 8'h5E : {4'hA, ~cs_pin, 3'b000}, a);
            check_flag(a, 1'b0);
            u_sep_master.stop();
        end
        guard = 1'b1;
        page_write(10'h235, 3, 1'b1);
        guard = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            pg = 10'(rnd());
            page_write(pg, k == 0 ? 1 : k == 1 ? 19 : 1 + int'(rnd() % 20), 1'b0);
            poll(pg[9:8]);
            read_check({pg[9:4], 4'h0}, 16);
        end
        read_check(10'h230, 16);
        read_check(10'h3FE, 3);
        u_sep_master.start();
        u_sep_master.put_byte(dev_byte(2'b00, 1'b1), a);
        u_sep_master.get_byte(1'b0, d);
        check_val(16'(d), 16'(exp_mem[1]));
        u_sep_master.stop();
        summarize();
    end
endmodule : sep_slave_tb
